// [bfs_exec.sv]
// Execution of branch, bit, flag, shift and indirect load operations
`timescale 1ns/1ns
`default_nettype none
`include "bfs_cfg.svh"
module bfs_exec
	import bfs_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Request from the instruction sequencer
	input  wire logic        start,
	input  wire bfs_op_t     op,
	input  wire logic [4:0]  dstAddr,
	input  wire logic [2:0]  bitSel,
	input  wire logic [7:0]  imm,
	input  wire logic [6:0]  branchOfs,
	input  wire logic [5:0]  ioAddrIn,
	input  wire logic [15:0] pcIn,
	output logic             busy,
	output logic             done,
	// Register file read data and pointers
	input  wire logic [7:0]  rdVal,
	input  wire logic [7:0]  rrVal,
	input  wire logic [15:0] rrPair,
	input  wire logic [15:0] xPtr,
	input  wire logic [15:0] yPtr,
	// Register file write back
	output logic             rfWrEn,
	output logic             rfWrPair,
	output logic [4:0]       rfWrAddr,
	output logic [15:0]      rfWrData,
	output logic             ptrWrEn,
	output logic             ptrSel,
	output logic [15:0]      ptrNew,
	// Program counter load
	output logic             pcLoad,
	output logic [15:0]      pcNew,
	// I/O space
	output logic             ioRd,
	output logic             ioWr,
	output logic [5:0]       ioAddr,
	output logic [7:0]       ioWrData,
	input  wire logic [7:0]  ioRdData,
	// Data memory
	output logic             memRd,
	output logic [15:0]      memAddr,
	input  wire logic [7:0]  memRdData,
	// Status flags
	output logic [7:0]       statusFlags
);

	bfs_regs_t  s_q;
	bfs_regs_t  s_d;
	logic [7:0] shRes;
	logic       shC;
	logic       shZ;
	logic       shN;
	logic       shV;

	// Replace one bit of a byte
	function automatic logic [7:0] putBit(input logic [7:0] v,
		input logic [2:0] b, input logic x);
		logic [7:0] r;
		r = v;
		r[b] = x;
		return r;
	endfunction

	// Pointer step up or down by one
	function automatic logic [15:0] ptrStep(input logic [15:0] p,
		input logic up);
		return up ? p + `BFS_PTR_STEP : p - `BFS_PTR_STEP;
	endfunction

	// Branch target: PC plus signed offset plus one
	function automatic logic [15:0] branchTarget(input logic [15:0] pc,
		input logic [6:0] k);
		return pc + {{9{k[6]}}, k} + `BFS_PC_STEP;
	endfunction

	bfs_shift shifter (
		.op       (op),
		.value    (rdVal),
		.carryIn  (s_q.status_flags[`BFS_FLAG_C]),
		.result   (shRes),
		.carryOut (shC),
		.zeroOut  (shZ),
		.negOut   (shN),
		.ovfOut   (shV)
	);

	// Next state; strobes default low so they last one cycle
	always_comb begin
		s_d          = s_q;
		s_d.done     = 1'b0;
		s_d.rfWrEn   = 1'b0;
		s_d.rfWrPair = 1'b0;
		s_d.pcLoad   = 1'b0;
		s_d.ioRd     = 1'b0;
		s_d.ioWr     = 1'b0;
		s_d.memRd    = 1'b0;
		s_d.ptrWrEn  = 1'b0;
		case (s_q.state)
			ST_IDLE: begin
				if (start) begin
					s_d.rfWrAddr = dstAddr;
					case (op)
						OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
							s_d.pcNew = branchTarget(pcIn, branchOfs);
							// Taken adds a cycle; not taken ends now
							if (s_q.status_flags[`BFS_FLAG_I] ==
								(op == OP_BRANCH_IRQ_ON)) begin
								s_d.state = ST_BRANCH;
							end else begin
								s_d.done = 1'b1;
							end
						end
						OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
							// Read first, modify and write next cycle
							s_d.ioRd    = 1'b1;
							s_d.ioAddr  = ioAddrIn;
							s_d.pendBit = bitSel;
							s_d.pendSet = (op == OP_IO_BIT_SET);
							s_d.state   = ST_IO;
						end
						OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT,
						OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY,
						OP_ARITH_SHIFT_RIGHT: begin
							s_d.rfWrEn   = 1'b1;
							s_d.rfWrData = {`BFS_ZERO_BYTE, shRes};
							s_d.status_flags[`BFS_FLAG_C] = shC;
							s_d.status_flags[`BFS_FLAG_Z] = shZ;
							s_d.status_flags[`BFS_FLAG_N] = shN;
							s_d.status_flags[`BFS_FLAG_V] = shV;
							s_d.done     = 1'b1;
						end
						OP_NIBBLE_SWAP: begin
							s_d.rfWrEn   = 1'b1;
							s_d.rfWrData = {`BFS_ZERO_BYTE, rdVal[3:0],
								rdVal[7:4]};
							s_d.done     = 1'b1;
						end
						OP_FLAG_BIT_SET, OP_FLAG_BIT_CLEAR: begin
							// Operand s selects the flag; others kept
							s_d.status_flags = putBit(s_q.status_flags, bitSel,
								op == OP_FLAG_BIT_SET);
							s_d.done = 1'b1;
						end
						OP_REGISTER_BIT_TO_TFLAG: begin
							s_d.status_flags[`BFS_FLAG_T] = rrVal[bitSel];
							s_d.done = 1'b1;
						end
						OP_TFLAG_TO_REGISTER_BIT: begin
							s_d.rfWrEn   = 1'b1;
							s_d.rfWrData = {`BFS_ZERO_BYTE, putBit(rdVal,
								bitSel, s_q.status_flags[`BFS_FLAG_T])};
							s_d.done     = 1'b1;
						end
						OP_COPY_REGISTER: begin
							s_d.rfWrEn   = 1'b1;
							s_d.rfWrData = {`BFS_ZERO_BYTE, rrVal};
							s_d.done     = 1'b1;
						end
						OP_COPY_REGISTER_PAIR: begin
							s_d.rfWrEn   = 1'b1;
							s_d.rfWrPair = 1'b1;
							s_d.rfWrData = rrPair;
							s_d.done     = 1'b1;
						end
						OP_LOAD_CONSTANT: begin
							s_d.rfWrEn   = 1'b1;
							s_d.rfWrData = {`BFS_ZERO_BYTE, imm};
							s_d.done     = 1'b1;
						end
						OP_INDIRECT_LOAD_X, OP_INDIRECT_LOAD_X_INC: begin
							s_d.memRd   = 1'b1;
							s_d.memAddr = xPtr;
							s_d.ptrSel  = `BFS_PTR_X;
							s_d.ptrNew  = ptrStep(xPtr, 1'b1);
							s_d.pendPtr = (op == OP_INDIRECT_LOAD_X_INC);
							s_d.state   = ST_LOAD;
						end
						OP_INDIRECT_LOAD_X_DEC: begin
							// Address is the already decremented pointer
							s_d.memRd   = 1'b1;
							s_d.memAddr = ptrStep(xPtr, 1'b0);
							s_d.ptrSel  = `BFS_PTR_X;
							s_d.ptrNew  = ptrStep(xPtr, 1'b0);
							s_d.pendPtr = 1'b1;
							s_d.state   = ST_LOAD;
						end
						OP_INDIRECT_LOAD_Y, OP_INDIRECT_LOAD_Y_INC: begin
							s_d.memRd   = 1'b1;
							s_d.memAddr = yPtr;
							s_d.ptrSel  = `BFS_PTR_Y;
							s_d.ptrNew  = ptrStep(yPtr, 1'b1);
							s_d.pendPtr = (op == OP_INDIRECT_LOAD_Y_INC);
							s_d.state   = ST_LOAD;
						end
						default: begin
							s_d.done = 1'b1;
						end
					endcase
				end
			end
			ST_BRANCH: begin
				s_d.pcLoad = 1'b1;
				s_d.done   = 1'b1;
				s_d.state  = ST_IDLE;
			end
			ST_IO: begin
				// Only the selected bit changes in the written byte
				s_d.ioWr     = 1'b1;
				s_d.ioWrData = putBit(ioRdData, s_q.pendBit,
					s_q.pendSet);
				s_d.done     = 1'b1;
				s_d.state    = ST_IDLE;
			end
			ST_LOAD: begin
				s_d.rfWrEn   = 1'b1;
				s_d.rfWrData = {`BFS_ZERO_BYTE, memRdData};
				s_d.ptrWrEn  = s_q.pendPtr;
				s_d.done     = 1'b1;
				s_d.state    = ST_IDLE;
			end
			default: begin
				s_d.state = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q      <= '0;
			s_q.state <= ST_IDLE;
			s_q.status_flags <= `BFS_STATUS_FLAGS_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Busy blocks new requests while a two-cycle operation runs
	assign busy        = (s_q.state != ST_IDLE);
	assign done        = s_q.done;
	assign rfWrEn      = s_q.rfWrEn;
	assign rfWrPair    = s_q.rfWrPair;
	assign rfWrAddr    = s_q.rfWrAddr;
	assign rfWrData    = s_q.rfWrData;
	assign ptrWrEn     = s_q.ptrWrEn;
	assign ptrSel      = s_q.ptrSel;
	assign ptrNew      = s_q.ptrNew;
	assign pcLoad      = s_q.pcLoad;
	assign pcNew       = s_q.pcNew;
	assign ioRd        = s_q.ioRd;
	assign ioWr        = s_q.ioWr;
	assign ioAddr      = s_q.ioAddr;
	assign ioWrData    = s_q.ioWrData;
	assign memRd       = s_q.memRd;
	assign memAddr     = s_q.memAddr;
	assign statusFlags = s_q.status_flags;

endmodule
`default_nettype wire

// [bfs_cfg.svh]
// Constants for the bit, flag, shift and load execution block
`ifndef BFS_CFG_SVH
`define BFS_CFG_SVH

// Status flag bit positions
`define BFS_FLAG_C     3'd0
`define BFS_FLAG_Z     3'd1
`define BFS_FLAG_N     3'd2
`define BFS_FLAG_V     3'd3
`define BFS_FLAG_S     3'd4
`define BFS_FLAG_H     3'd5
`define BFS_FLAG_T     3'd6
`define BFS_FLAG_I     3'd7

// Reset and step values
`define BFS_STATUS_FLAGS_RST   8'h00
`define BFS_PTR_STEP   16'h0001
`define BFS_PC_STEP    16'h0001
`define BFS_ZERO_BYTE  8'h00
`define BFS_MSB        3'd7
`define BFS_LSB        3'd0

// Pointer selectors
`define BFS_PTR_X      1'b0
`define BFS_PTR_Y      1'b1

`endif

// [bfs_pkg.sv]
// Types shared by the execution block and its shift unit
`default_nettype none
package bfs_pkg;

	// Operations issued by the instruction sequencer
	typedef enum logic [4:0] {
		OP_BRANCH_IRQ_ON        = 5'h00,
		OP_BRANCH_IRQ_OFF       = 5'h01,
		OP_IO_BIT_SET           = 5'h02,
		OP_IO_BIT_CLEAR         = 5'h03,
		OP_LOGICAL_SHIFT_LEFT   = 5'h04,
		OP_LOGICAL_SHIFT_RIGHT  = 5'h05,
		OP_ROTATE_LEFT_CARRY    = 5'h06,
		OP_ROTATE_RIGHT_CARRY   = 5'h07,
		OP_ARITH_SHIFT_RIGHT    = 5'h08,
		OP_NIBBLE_SWAP          = 5'h09,
		OP_FLAG_BIT_SET         = 5'h0a,
		OP_FLAG_BIT_CLEAR       = 5'h0b,
		OP_REGISTER_BIT_TO_TFLAG = 5'h0c,
		OP_TFLAG_TO_REGISTER_BIT = 5'h0d,
		OP_COPY_REGISTER        = 5'h0e,
		OP_COPY_REGISTER_PAIR   = 5'h0f,
		OP_LOAD_CONSTANT        = 5'h10,
		OP_INDIRECT_LOAD_X      = 5'h11,
		OP_INDIRECT_LOAD_X_INC  = 5'h12,
		OP_INDIRECT_LOAD_X_DEC  = 5'h13,
		OP_INDIRECT_LOAD_Y      = 5'h14,
		OP_INDIRECT_LOAD_Y_INC  = 5'h15
	} bfs_op_t;

	// One-hot sequencing states
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_BRANCH = 4'b0010,
		ST_IO     = 4'b0100,
		ST_LOAD   = 4'b1000
	} bfs_state_t;

	// Whole state of the execution block
	typedef struct packed {
		bfs_state_t  state;
		logic [7:0]  status_flags;
		logic        done;
		logic        rfWrEn;
		logic        rfWrPair;
		logic [4:0]  rfWrAddr;
		logic [15:0] rfWrData;
		logic        pcLoad;
		logic [15:0] pcNew;
		logic        ioRd;
		logic        ioWr;
		logic [5:0]  ioAddr;
		logic [7:0]  ioWrData;
		logic [2:0]  pendBit;
		logic        pendSet;
		logic        memRd;
		logic [15:0] memAddr;
		logic        ptrWrEn;
		logic        ptrSel;
		logic [15:0] ptrNew;
		logic        pendPtr;
	} bfs_regs_t;

endpackage
`default_nettype wire

// [bfs_shift.sv]
// Shift and rotate unit with its flag results
`timescale 1ns/1ns
`default_nettype none
`include "bfs_cfg.svh"
module bfs_shift
	import bfs_pkg::*;
(
	// Operation and operand
	input  wire bfs_op_t   op,
	input  wire logic [7:0] value,
	input  wire logic       carryIn,
	// Result and flags
	output logic [7:0]      result,
	output logic            carryOut,
	output logic            zeroOut,
	output logic            negOut,
	output logic            ovfOut
);

	// Result and carry per shift kind
	always_comb begin
		result   = value;
		carryOut = carryIn;
		case (op)
			OP_LOGICAL_SHIFT_LEFT: begin
				result   = {value[6:0], 1'b0};
				carryOut = value[`BFS_MSB];
			end
			OP_LOGICAL_SHIFT_RIGHT: begin
				result   = {1'b0, value[7:1]};
				carryOut = value[`BFS_LSB];
			end
			OP_ROTATE_LEFT_CARRY: begin
				result   = {value[6:0], carryIn};
				carryOut = value[`BFS_MSB];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				result   = {carryIn, value[7:1]};
				carryOut = value[`BFS_LSB];
			end
			OP_ARITH_SHIFT_RIGHT: begin
				result   = {value[7], value[7:1]};
				carryOut = value[`BFS_LSB];
			end
			default: begin
				result   = value;
				carryOut = carryIn;
			end
		endcase
	end

	// Flags common to every shift; overflow is negative xor carry
	assign zeroOut = (result == `BFS_ZERO_BYTE);
	assign negOut  = result[`BFS_MSB];
	assign ovfOut  = negOut ^ carryOut;

endmodule
`default_nettype wire

// [bfs_mem_model.sv]
// Far-side model: I/O space and data memory read ports
`timescale 1ns/1ns
`default_nettype none
module bfs_mem_model (
	// Clock
	input  wire logic        clock,
	// Read requests from the block
	input  wire logic        ioRd,
	input  wire logic [5:0]  ioAddr,
	input  wire logic        memRd,
	input  wire logic [15:0] memAddr,
	// Read data back to the block
	output logic [7:0]       ioRdData,
	output logic [7:0]       memRdData
);
	logic [7:0] ioLast_q  = 8'h00;
	logic [7:0] memLast_q = 8'h00;
	// Unselected buses flip so stale data never passes
	always_ff @(posedge clock) begin
		ioLast_q  <= ioRdData;
		memLast_q <= memRdData;
	end
	// Contents follow the address; writes are not kept
	assign ioRdData  = ioRd ? {2'b10, ioAddr} : ~ioLast_q;
	assign memRdData = memRd ? (memAddr[7:0] ^ 8'ha5) : ~memLast_q;
endmodule
`default_nettype wire

// [bfs_exec_chk.sv]
// Port-level assertions for the execution block
`timescale 1ns/1ns
`default_nettype none
module bfs_exec_chk import bfs_pkg::*; (
	// Clock, reset and request
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire bfs_op_t     op,
	input  wire logic [2:0]  bitSel,
	input  wire logic [6:0]  branchOfs,
	input  wire logic [15:0] pcIn,
	input  wire logic        busy,
	input  wire logic        done,
	// Operands
	input  wire logic [7:0]  rdVal,
	input  wire logic [15:0] xPtr,
	// Results
	input  wire logic        rfWrEn,
	input  wire logic [15:0] rfWrData,
	input  wire logic        ptrWrEn,
	input  wire logic [15:0] ptrNew,
	input  wire logic        pcLoad,
	input  wire logic [15:0] pcNew,
	input  wire logic        ioRd,
	input  wire logic        ioWr,
	input  wire logic [7:0]  ioWrData,
	input  wire logic [7:0]  ioRdData,
	input  wire logic        memRd,
	input  wire logic [15:0] memAddr,
	input  wire logic [7:0]  memRdData,
	input  wire logic [7:0]  statusFlags
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic        go;
	logic [15:0] tgt;
	// Accepted request and relative branch target
	assign go  = start & ~busy;
	assign tgt = pcIn + {{9{branchOfs[6]}}, branchOfs} + 16'h0001;
	// First cycle of the two-cycle operations
	sequence io_wait; !done && ioRd && !ioWr; endsequence
	sequence ld_wait; !done && memRd; endsequence
	io_set_a: assert property (go && op == OP_IO_BIT_SET |=> io_wait
		##1 (ioWr && done && ioWrData == ($past(ioRdData)
		| (8'h01 << $past(bitSel, 2))))) else $error("io bit set wrong");
	br_on_a: assert property (go && op == OP_BRANCH_IRQ_ON
		&& statusFlags[7] |=> !done ##1 (done && pcLoad
		&& pcNew == $past(tgt, 2))) else $error("taken branch wrong");
	br_off_a: assert property (go && op == OP_BRANCH_IRQ_OFF
		&& statusFlags[7] |=> done && !pcLoad && $stable(statusFlags))
		else $error("untaken branch wrong");
	shl_a: assert property (go && op == OP_LOGICAL_SHIFT_LEFT |=> done
		&& rfWrData[7:0] == {$past(rdVal[6:0]), 1'b0}
		&& statusFlags[0] == $past(rdVal[7])) else $error("shl wrong");
	ror_a: assert property (go && op == OP_ROTATE_RIGHT_CARRY |=>
		rfWrData[7:0] == {$past(statusFlags[0]), $past(rdVal[7:1])}
		&& statusFlags[0] == $past(rdVal[0])) else $error("ror wrong");
	asr_a: assert property (go && op == OP_ARITH_SHIFT_RIGHT |=>
		rfWrData[7:0] == {$past(rdVal[7]), $past(rdVal[7:1])})
		else $error("asr wrong");
	shift_flags_a: assert property (go && op inside {
		OP_LOGICAL_SHIFT_LEFT, OP_LOGICAL_SHIFT_RIGHT, OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT}
		|=> statusFlags[2] == rfWrData[7]
		&& statusFlags[3] == (statusFlags[2] ^ statusFlags[0])
		&& statusFlags[1] == (rfWrData[7:0] == 8'h00))
		else $error("shift flags wrong");
	flag_set_a: assert property (go && op == OP_FLAG_BIT_SET |=> done
		&& statusFlags == ($past(statusFlags) | (8'h01 << $past(bitSel))))
		else $error("flag set wrong");
	ld_dec_a: assert property (go && op == OP_INDIRECT_LOAD_X_DEC |=>
		ld_wait ##0 memAddr == $past(xPtr) - 16'h0001 ##1 (done && rfWrEn
		&& ptrWrEn && ptrNew == $past(xPtr, 2) - 16'h0001
		&& rfWrData[7:0] == $past(memRdData))) else $error("ld dec wrong");
endmodule
bind bfs_exec bfs_exec_chk i_chk (.clock, .rst, .start, .op, .bitSel,
	.branchOfs, .pcIn, .busy, .done, .rdVal, .xPtr, .rfWrEn, .rfWrData,
	.ptrWrEn, .ptrNew, .pcLoad, .pcNew, .ioRd, .ioWr, .ioWrData,
	.ioRdData, .memRd, .memAddr, .memRdData, .statusFlags);
`default_nettype wire

// [tb_bfs_exec.sv]
// Self-checking bench for the bit, flag, shift and load block
`timescale 1ns/1ns
`default_nettype none
module tb_bfs_exec import bfs_pkg::*; ;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	bfs_op_t     op = OP_LOAD_CONSTANT;
	logic [2:0]  bitSel = 3'h0;
	logic [7:0]  rdVal = 8'h00, rrVal = 8'h08, imm = 8'h77;
	logic [6:0]  branchOfs = 7'h00;
	logic [15:0] pcIn = 16'h0100, rrPair = 16'hbeef;
	logic [15:0] xPtr = 16'h0210, yPtr = 16'h0333;
	logic        busy, done, rfWrEn, rfWrPair, ptrWrEn, ptrSel;
	logic        pcLoad, ioRd, ioWr, memRd;
	logic [4:0]  rfWrAddr;
	logic [5:0]  ioAddr;
	logic [15:0] rfWrData, ptrNew, pcNew, memAddr;
	logic [7:0]  ioWrData, ioRdData, memRdData, statusFlags;
	int          failures = 0, n_tests = 0, cyc = 0, n;
	bfs_exec i_dut (.clock, .rst, .start, .op, .dstAddr(5'h11), .bitSel,
		.imm, .branchOfs, .ioAddrIn(6'h12), .pcIn, .busy, .done, .rdVal,
		.rrVal, .rrPair, .xPtr, .yPtr, .rfWrEn, .rfWrPair, .rfWrAddr,
		.rfWrData, .ptrWrEn, .ptrSel, .ptrNew, .pcLoad, .pcNew, .ioRd,
		.ioWr, .ioAddr, .ioWrData, .ioRdData, .memRd, .memAddr,
		.memRdData, .statusFlags);
	bfs_mem_model i_mem (.clock, .ioRd, .ioAddr, .memRd, .memAddr,
		.ioRdData, .memRdData);
	// 10 MHz clock and a hang guard well past the expected run
	always #50 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One request; cycles to done are counted and compared
	task automatic run(input bfs_op_t o, input logic [2:0] b,
		input logic [7:0] rd, input int cycles);
		@(posedge clock);
		op <= o;
		bitSel <= b;
		rdVal <= rd;
		start <= 1'b1;
		@(posedge clock);
		start <= 1'b0;
		#1;
		chk(16'(busy), 16'(cycles - 1));
		n = 1;
		while (done !== 1'b1 && n < 4) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk(16'(n), 16'(cycles));
	endtask
	// Shift table walks the carry through every operation
	task automatic t_shift();
		bfs_op_t op_l [7] = '{OP_LOGICAL_SHIFT_LEFT, OP_ROTATE_LEFT_CARRY,
			OP_ROTATE_RIGHT_CARRY, OP_ROTATE_RIGHT_CARRY,
			OP_LOGICAL_SHIFT_RIGHT, OP_ARITH_SHIFT_RIGHT, OP_NIBBLE_SWAP};
		logic [7:0] in_l [7] = '{8'h80, 8'h01, 8'h01, 8'h02, 8'h81,
			8'h81, 8'ha5};
		logic [7:0] re_l [7] = '{8'h00, 8'h03, 8'h00, 8'h81, 8'h40, 8'hc0, 8'h5a};
		logic [3:0] fl_l [7] = '{4'hb, 4'h0, 4'hb, 4'hc, 4'h9, 4'h5, 4'h5};
		for (int i = 0; i < 7; i++) begin
			run(op_l[i], 3'h0, in_l[i], 1);
			chk(rfWrData, {8'h00, re_l[i]});
			chk({8'h00, statusFlags}, {12'h000, fl_l[i]});
		end
		$display("shift test done");
	endtask
	// Each flag set then cleared, the rest must hold
	task automatic t_flag();
		logic [7:0] exp;
		exp = 8'h05;
		for (int s = 0; s < 8; s++) begin
			run(OP_FLAG_BIT_SET, 3'(s), 8'h00, 1);
			exp[s] = 1'b1;
			chk({8'h00, statusFlags}, {8'h00, exp});
		end
		for (int s = 7; s >= 0; s--) begin
			run(OP_FLAG_BIT_CLEAR, 3'(s), 8'h00, 1);
			exp[s] = 1'b0;
			chk({8'h00, statusFlags}, {8'h00, exp});
		end
		$display("flag test done");
	endtask
	// T flag store and load, then both branch kinds
	task automatic t_tbr();
		run(OP_REGISTER_BIT_TO_TFLAG, 3'h3, 8'h00, 1);
		chk({8'h00, statusFlags}, 16'h0040);
		run(OP_TFLAG_TO_REGISTER_BIT, 3'h1, 8'h80, 1);
		chk(rfWrData, 16'h0082);
		@(posedge clock);
		branchOfs <= 7'h7e;
		run(OP_BRANCH_IRQ_ON, 3'h0, 8'h00, 1);
		chk(16'(pcLoad), 16'h0000);
		run(OP_BRANCH_IRQ_OFF, 3'h0, 8'h00, 2);
		chk(pcNew, 16'h00ff);
		run(OP_FLAG_BIT_SET, 3'h7, 8'h00, 1);
		@(posedge clock);
		branchOfs <= 7'h05;
		run(OP_BRANCH_IRQ_ON, 3'h0, 8'h00, 2);
		chk(pcNew, 16'h0106);
		run(OP_BRANCH_IRQ_OFF, 3'h0, 8'h00, 1);
		chk({7'h00, pcLoad, statusFlags}, 16'h00c0);
		$display("bit and branch test done");
	endtask
	// I/O bit writes keep the unselected bits
	task automatic t_io();
		run(OP_IO_BIT_SET, 3'h2, 8'h00, 2);
		chk({7'h00, ioWr, ioWrData}, 16'h0196);
		chk({10'h000, ioAddr}, 16'h0012);
		run(OP_IO_BIT_CLEAR, 3'h7, 8'h00, 2);
		chk({7'h00, ioWr, ioWrData}, 16'h0112);
		$display("io test done");
	endtask
	// Load with pointer write-back flag in bit 16
	task automatic ld(input bfs_op_t o, input logic [7:0] d,
		input logic [16:0] p);
		run(o, 3'h0, 8'h00, 2);
		chk(rfWrData, {8'h00, d});
		chk({15'h0000, ptrWrEn}, {15'h0000, p[16]});
		chk({15'h0000, ptrSel}, {15'h0000, o inside {OP_INDIRECT_LOAD_Y,
			OP_INDIRECT_LOAD_Y_INC}});
		if (p[16]) chk(ptrNew, p[15:0]);
	endtask
	task automatic t_load();
		ld(OP_INDIRECT_LOAD_X, 8'hb5, 17'h00000);
		ld(OP_INDIRECT_LOAD_X_INC, 8'hb5, 17'h10211);
		ld(OP_INDIRECT_LOAD_X_DEC, 8'haa, 17'h1020f);
		ld(OP_INDIRECT_LOAD_Y, 8'h96, 17'h00000);
		ld(OP_INDIRECT_LOAD_Y_INC, 8'h96, 17'h10334);
		$display("load test done");
	endtask
	// Copies and constant load leave the flags alone
	task automatic t_copy();
		run(OP_COPY_REGISTER, 3'h0, 8'h00, 1);
		chk({rfWrAddr, 3'h0, rfWrData[7:0]}, 16'h8808);
		run(OP_COPY_REGISTER_PAIR, 3'h0, 8'h00, 1);
		chk(rfWrData, 16'hbeef);
		chk({15'h0000, rfWrPair}, 16'h0001);
		run(OP_LOAD_CONSTANT, 3'h0, 8'h00, 1);
		chk({rfWrData[7:0], statusFlags}, 16'h77c0);
		$display("copy test done");
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_shift();
		t_flag();
		t_tbr();
		t_io();
		t_load();
		t_copy();
		report_and_stop();
	end
endmodule
`default_nettype wire
